// ---- logic/pcu_config_unlock.v ----
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "pcu_config_unlock_regs.vh"

// Summary of operation
// - two back-to-back writes of 55h to the index port open configuration mode
// - any other write between the two key writes restarts the key sequence
// - writing AAh to the index port closes configuration mode
// - index port picks a register number; data port reaches that register
// - index register is write-only and loads only in configuration mode
// - configuration bytes reset only at power-up, not on ordinary reset
// - port mode/base register at number 01h, power-up value 9Fh
// - bit 3 set means compatibility, clear means extended operation
// - bits 1:0 place the port base or disable the port
// - extended submode register at number 04h, power-up value 00h
// - submode bits pick standard, EPP, ECP or ECP plus EPP
// - compatibility bit set overrides the submode bits
// - in ECP submodes mode field 000 gives standard; 100 gives EPP only in ECP plus EPP
// - FIFO threshold register at number 0Ah, power-up value 00h
module pcu_config_unlock (
	input wire CORE_CLK,
	input wire SYS_RST,
	input wire PWRUP_RST,
	input wire [31:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output wire [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	input wire [2:0] EXTENDED_CONTROL_MODE_FIELD,
	output wire CONFIG_MODE,
	output wire PORT_ENABLE,
	output wire [31:0] PORT_BASE_ADDR,
	output wire MODE_COMPAT,
	output wire MODE_STANDARD_PARALLEL_OPERATION,
	output wire MODE_EPP,
	output wire MODE_ECP,
	output wire [7:0] FIFO_THRESHOLD
);

	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_HALF = 3'h2;
	localparam [2:0] ST_CFG = 3'h4;

	reg ack_r;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] index_r;
	reg [7:0] index_nxt;
	reg [31:0] base_r;
	reg [31:0] base_nxt;
	reg port_en_r;
	reg mode_compat_r;
	reg mode_std_r;
	reg mode_epp_r;
	reg mode_ecp_r;
	reg mode_compat_nxt;
	reg mode_std_nxt;
	reg mode_epp_nxt;
	reg mode_ecp_nxt;
	reg [7:0] thr_r;

	wire req;
	wire wr_fire;
	wire lane0;
	wire [7:0] wbyte;
	wire hit_index;
	wire hit_data;
	wire hit_status;
	wire in_cfg;
	wire sel_mode_base;
	wire sel_submode;
	wire sel_thr;
	wire wr_data_port;
	wire [7:0] mode_base;
	wire [7:0] submode;
	wire [7:0] thr;
	wire [1:0] base_sel;
	wire [1:0] sub_sel;
	wire key_write;
	wire exit_write;
	wire wr_mode_base;
	wire wr_submode;
	wire wr_thr;
	wire [31:0] status_word;

	// one wait state: the request is seen, then answered at the next edge
	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_r;
	assign wr_fire = AVS_WRITE & ack_r;

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	assign lane0 = AVS_BYTEENABLE[0];
	assign wbyte = AVS_WRITEDATA[7:0];
	assign hit_index = (AVS_ADDRESS == `PCU_IDX_INDEX_PORT);
	assign hit_data = (AVS_ADDRESS == `PCU_IDX_DATA_PORT);
	assign hit_status = (AVS_ADDRESS == `PCU_IDX_STATUS);
	assign in_cfg = state_r[2];

	// a key byte only counts when it really lands in the low lane
	assign key_write = wr_fire & hit_index & lane0 & (wbyte == `PCU_KEY_UNLOCK);
	assign exit_write = wr_fire & hit_index & lane0 & (wbyte == `PCU_KEY_EXIT);

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (key_write) begin
					state_nxt = ST_HALF;
				end
			end
			ST_HALF: begin
				if (key_write) begin
					state_nxt = ST_CFG;
				end else if (wr_fire) begin
					// reads in between do not break the key, writes do
					state_nxt = ST_IDLE;
				end
			end
			ST_CFG: begin
				if (exit_write) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// the index is cleared on leaving so a fresh session must load it again
	always @* begin
		index_nxt = index_r;
		if (in_cfg & wr_fire & hit_index & lane0) begin
			if (exit_write) begin
				index_nxt = `PCU_RST_INDEX;
			end else begin
				index_nxt = wbyte;
			end
		end
	end

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			index_r <= `PCU_RST_INDEX;
		end else begin
			index_r <= index_nxt;
		end
	end

	assign sel_mode_base = (index_r == `PCU_SEL_PORT_MODE_BASE);
	assign sel_submode = (index_r == `PCU_SEL_EXT_SUBMODE);
	assign sel_thr = (index_r == `PCU_SEL_FIFO_THRESHOLD);
	assign wr_data_port = in_cfg & wr_fire & hit_data & lane0;
	assign wr_mode_base = wr_data_port & sel_mode_base;
	assign wr_submode = wr_data_port & sel_submode;
	assign wr_thr = wr_data_port & sel_thr;

	// bit 7 of the submode byte is stored as written; keeping it zero is up to software
	pcu_cfg_byte #(
		.RESET_VAL(`PCU_RST_PORT_MODE_BASE)
	) u_mode_base (
		.clk(CORE_CLK),
		.pwrup_rst(PWRUP_RST),
		.wr_en(wr_mode_base),
		.wr_data(wbyte),
		.value(mode_base)
	);

	pcu_cfg_byte #(
		.RESET_VAL(`PCU_RST_EXT_SUBMODE)
	) u_submode (
		.clk(CORE_CLK),
		.pwrup_rst(PWRUP_RST),
		.wr_en(wr_submode),
		.wr_data(wbyte),
		.value(submode)
	);

	pcu_cfg_byte #(
		.RESET_VAL(`PCU_RST_FIFO_THRESHOLD)
	) u_thr (
		.clk(CORE_CLK),
		.pwrup_rst(PWRUP_RST),
		.wr_en(wr_thr),
		.wr_data(wbyte),
		.value(thr)
	);

	assign base_sel = mode_base[`PCU_BASE_HI:`PCU_BASE_LO];
	assign sub_sel = submode[`PCU_SUB_HI:`PCU_SUB_LO];

	always @* begin
		case (base_sel)
			`PCU_BASE_SEL_A: base_nxt = `PCU_BASE_ADDR_A;
			`PCU_BASE_SEL_B: base_nxt = `PCU_BASE_ADDR_B;
			`PCU_BASE_SEL_C: base_nxt = `PCU_BASE_ADDR_C;
			default: base_nxt = 32'h00000000;
		endcase
	end

	// effective operating mode, one of four flags high at a time
	always @* begin
		mode_compat_nxt = 1'b0;
		mode_std_nxt = 1'b0;
		mode_epp_nxt = 1'b0;
		mode_ecp_nxt = 1'b0;
		if (mode_base[`PCU_BIT_COMPAT]) begin
			mode_compat_nxt = 1'b1;
		end else begin
			case (sub_sel)
				`PCU_SUB_STD: begin
					mode_std_nxt = 1'b1;
				end
				`PCU_SUB_EPP: begin
					mode_epp_nxt = 1'b1;
				end
				`PCU_SUB_ECP: begin
					if (EXTENDED_CONTROL_MODE_FIELD == `PCU_ECM_STD) begin
						mode_std_nxt = 1'b1;
					end else begin
						mode_ecp_nxt = 1'b1;
					end
				end
				default: begin
					if (EXTENDED_CONTROL_MODE_FIELD == `PCU_ECM_STD) begin
						mode_std_nxt = 1'b1;
					end else if (EXTENDED_CONTROL_MODE_FIELD == `PCU_ECM_EPP) begin
						mode_epp_nxt = 1'b1;
					end else begin
						mode_ecp_nxt = 1'b1;
					end
				end
			endcase
		end
	end

	// decoded outputs follow the stored bytes one cycle later;
	// they are not cleared by the ordinary reset since the bytes survive it
	// base and enable share base_sel, so they always change on the same edge
	always @(posedge CORE_CLK) begin
		if (PWRUP_RST) begin
			base_r <= 32'h00000000;
			port_en_r <= 1'b0;
		end else begin
			base_r <= base_nxt;
			port_en_r <= (base_sel != `PCU_BASE_OFF);
		end
	end

	always @(posedge CORE_CLK) begin
		if (PWRUP_RST) begin
			mode_compat_r <= 1'b0;
			mode_std_r <= 1'b0;
			mode_epp_r <= 1'b0;
			mode_ecp_r <= 1'b0;
		end else begin
			mode_compat_r <= mode_compat_nxt;
			mode_std_r <= mode_std_nxt;
			mode_epp_r <= mode_epp_nxt;
			mode_ecp_r <= mode_ecp_nxt;
		end
	end

	// the threshold copy needs no decode, only the same one-cycle delay as the flags
	always @(posedge CORE_CLK) begin
		if (PWRUP_RST) begin
			thr_r <= 8'h00;
		end else begin
			thr_r <= thr;
		end
	end

	// status word: a read-only view of the mode and key progress, handy for bring-up
	assign status_word[31:6] = 26'h0000000;
	assign status_word[`PCU_ST_CFG] = in_cfg;
	assign status_word[`PCU_ST_KEY] = state_r[1];
	assign status_word[`PCU_ST_COMPAT] = mode_compat_r;
	assign status_word[`PCU_ST_STD] = mode_std_r;
	assign status_word[`PCU_ST_EPP] = mode_epp_r;
	assign status_word[`PCU_ST_ECP] = mode_ecp_r;

	// read data are captured while waitrequest is still high
	always @* begin
		rdata_nxt = 32'h00000000;
		if (hit_data & in_cfg) begin
			if (sel_mode_base) begin
				rdata_nxt[7:0] = mode_base;
			end else if (sel_submode) begin
				rdata_nxt[7:0] = submode;
			end else if (sel_thr) begin
				rdata_nxt[7:0] = thr;
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end else if (hit_status) begin
			rdata_nxt = status_word;
		end
	end

	always @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rdata_r <= 32'h00000000;
		end else if (AVS_READ & ~ack_r) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign AVS_READDATA = rdata_r;
	assign CONFIG_MODE = in_cfg;
	assign PORT_ENABLE = port_en_r;
	assign PORT_BASE_ADDR = base_r;
	assign MODE_COMPAT = mode_compat_r;
	assign MODE_STANDARD_PARALLEL_OPERATION = mode_std_r;
	assign MODE_EPP = mode_epp_r;
	assign MODE_ECP = mode_ecp_r;
	assign FIFO_THRESHOLD = thr_r;

endmodule

`default_nettype wire

// ---- logic/pcu_config_unlock_regs.vh ----
`ifndef PCU_CONFIG_UNLOCK_REGS_VH
`define PCU_CONFIG_UNLOCK_REGS_VH

// register indices (word address on the bus, byte address is four times this)
`define PCU_IDX_INDEX_PORT 32'h220007f0
`define PCU_IDX_DATA_PORT 32'h220007f1
`define PCU_IDX_STATUS 32'h220007f2

// key values written to the index port
`define PCU_KEY_UNLOCK 8'h55
`define PCU_KEY_EXIT 8'haa

// configuration register numbers selected through the index port
`define PCU_SEL_PORT_MODE_BASE 8'h01
`define PCU_SEL_EXT_SUBMODE 8'h04
`define PCU_SEL_FIFO_THRESHOLD 8'h0a

// power-up values; the index value is the one that the ordinary reset loads
`define PCU_RST_PORT_MODE_BASE 8'h9f
`define PCU_RST_EXT_SUBMODE 8'h00
`define PCU_RST_FIFO_THRESHOLD 8'h00
`define PCU_RST_INDEX 8'h00

// field positions
`define PCU_BIT_COMPAT 3
`define PCU_BASE_HI 1
`define PCU_BASE_LO 0
`define PCU_SUB_HI 1
`define PCU_SUB_LO 0

// base address selection codes and addresses
`define PCU_BASE_OFF 2'h0
`define PCU_BASE_SEL_A 2'h1
`define PCU_BASE_SEL_B 2'h2
`define PCU_BASE_SEL_C 2'h3
`define PCU_BASE_ADDR_A 32'h22000778
`define PCU_BASE_ADDR_B 32'h220007bc
`define PCU_BASE_ADDR_C 32'h22000678

// extended submode codes
`define PCU_SUB_STD 2'h0
`define PCU_SUB_EPP 2'h1
`define PCU_SUB_ECP 2'h2
`define PCU_SUB_ECP_EPP 2'h3

// extended control mode field codes
`define PCU_ECM_STD 3'h0
`define PCU_ECM_EPP 3'h4

// status word fields
`define PCU_ST_CFG 0
`define PCU_ST_KEY 1
`define PCU_ST_COMPAT 2
`define PCU_ST_STD 3
`define PCU_ST_EPP 4
`define PCU_ST_ECP 5

`endif

// ---- logic/pcu_cfg_byte.v ----
`timescale 1ns/1ps
`default_nettype none

// configuration byte that only the power-up reset restores
module pcu_cfg_byte #(
	parameter [7:0] RESET_VAL = 8'h00
) (
	input wire clk,
	input wire pwrup_rst,
	input wire wr_en,
	input wire [7:0] wr_data,
	output wire [7:0] value
);

	reg [7:0] value_r;

	always @(posedge clk) begin
		if (pwrup_rst) begin
			value_r <= RESET_VAL;
		end else if (wr_en) begin
			value_r <= wr_data;
		end
	end

	assign value = value_r;

endmodule

`default_nettype wire

// ---- tb/pcu_cfg_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcu_config_unlock_regs.vh"
module pcu_cfg_monitor (
	input wire CORE_CLK,
	input wire SYS_RST,
	input wire PWRUP_RST,
	input wire [31:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	input wire [31:0] AVS_READDATA,
	input wire AVS_WAITREQUEST,
	input wire CONFIG_MODE,
	input wire PORT_ENABLE,
	input wire [31:0] PORT_BASE_ADDR,
	input wire MODE_COMPAT,
	input wire MODE_STANDARD_PARALLEL_OPERATION,
	input wire MODE_EPP,
	input wire MODE_ECP,
	input wire [7:0] FIFO_THRESHOLD
);
	wire acc_wr = AVS_WRITE && !AVS_WAITREQUEST;
	wire acc_rd = AVS_READ && !AVS_WAITREQUEST;
	wire at_ix = AVS_ADDRESS == `PCU_IDX_INDEX_PORT;
	wire at_dp = AVS_ADDRESS == `PCU_IDX_DATA_PORT;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_key(v);
		acc_wr && at_ix && AVS_BYTEENABLE[0] && AVS_WRITEDATA[7:0] == v;
	endsequence
	a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request waited more than one cycle");
	// two keys three cycles apart, the spacing the testbench bus task gives; no other access can fit between them
	a_key_enter: assert property (!CONFIG_MODE ##0 s_key(8'h55) ##3 s_key(8'h55) |=> CONFIG_MODE)
		else $error("unlock keys did not open the mode");
	a_key_exit: assert property (CONFIG_MODE ##0 s_key(`PCU_KEY_EXIT) |=> !CONFIG_MODE)
		else $error("exit key did not close the mode");
	a_index_wo: assert property (acc_rd && at_ix |-> AVS_READDATA == 32'h0)
		else $error("index port read not zero");
	a_closed_zero: assert property (acc_rd && at_dp && !CONFIG_MODE |-> AVS_READDATA == 32'h0)
		else $error("data port read outside mode not zero");
	a_base_map: assert property (PORT_ENABLE ? PORT_BASE_ADDR inside {`PCU_BASE_ADDR_A,
		`PCU_BASE_ADDR_B, `PCU_BASE_ADDR_C} : PORT_BASE_ADDR == 32'h0)
		else $error("port base inconsistent with enable");
	a_mode_onehot: assert property (!PWRUP_RST && !$past(PWRUP_RST) |-> $onehot({MODE_COMPAT,
		MODE_STANDARD_PARALLEL_OPERATION, MODE_EPP, MODE_ECP}))
		else $error("mode outputs not one-hot");
	a_thresh_cause: assert property (!$stable(FIFO_THRESHOLD) && !$past(PWRUP_RST) &&
		!$past(PWRUP_RST, 2) |-> $past(acc_wr && at_dp) || $past(acc_wr && at_dp, 2))
		else $error("threshold changed without a data write");
	a_keep_reset: assert property (disable iff (PWRUP_RST) SYS_RST |=> $stable(FIFO_THRESHOLD) &&
		$stable(PORT_BASE_ADDR))
		else $error("ordinary reset disturbed configuration");
endmodule
`default_nettype wire

// ---- tb/pcu_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcu_config_unlock_regs.vh"
module tb;
	localparam [31:0] ix = `PCU_IDX_INDEX_PORT;
	localparam [31:0] dp = `PCU_IDX_DATA_PORT;
	reg CORE_CLK = 1'b0, SYS_RST = 1'b1, PWRUP_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	reg [31:0] AVS_ADDRESS = 32'h0, AVS_WRITEDATA = 32'h0;
	reg [3:0] AVS_BYTEENABLE = 4'h1;
	reg [2:0] EXTENDED_CONTROL_MODE_FIELD = 3'h0;
	wire [31:0] AVS_READDATA, PORT_BASE_ADDR;
	wire [7:0] FIFO_THRESHOLD;
	wire AVS_WAITREQUEST, CONFIG_MODE, PORT_ENABLE, MODE_COMPAT;
	wire MODE_STANDARD_PARALLEL_OPERATION, MODE_EPP, MODE_ECP;
	integer mismatches = 0, tests_run = 0, i, cfg, half, sel, m;
	// -1 marks numbers with no register behind them
	integer mdl [0:255];
	reg [16:0] seed = 17'h10551;
	reg [31:0] q;
	reg [7:0] d, s;
	pcu_config_unlock pcu_config_unlock_inst (
		.CORE_CLK(CORE_CLK),
		.SYS_RST(SYS_RST),
		.PWRUP_RST(PWRUP_RST),
		.AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST),
		.EXTENDED_CONTROL_MODE_FIELD(EXTENDED_CONTROL_MODE_FIELD),
		.CONFIG_MODE(CONFIG_MODE),
		.PORT_ENABLE(PORT_ENABLE),
		.PORT_BASE_ADDR(PORT_BASE_ADDR),
		.MODE_COMPAT(MODE_COMPAT),
		.MODE_STANDARD_PARALLEL_OPERATION(MODE_STANDARD_PARALLEL_OPERATION),
		.MODE_EPP(MODE_EPP),
		.MODE_ECP(MODE_ECP),
		.FIFO_THRESHOLD(FIFO_THRESHOLD)
	);
	initial forever #20 CORE_CLK = ~CORE_CLK;
	function [16:0] lfsr(input [16:0] v);
		lfsr = {v[15:0], v[16] ^ v[13]};
	endfunction
	task summarize;
		if (mismatches == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	task bus(input w, input [31:0] a, input [7:0] v);
		integer n;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, v};
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n = n + 1;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		if (AVS_WAITREQUEST !== 1'b0) begin
			mismatches = mismatches + 1;
			summarize;
		end
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task wr(input [31:0] a, input [7:0] v);
		bus(1'b1, a, v);
		if (cfg) begin
			if (a == ix) begin
				cfg = v != `PCU_KEY_EXIT;
				sel = cfg ? v : 0;
			end else if (a == dp && mdl[sel] >= 0) mdl[sel] = v;
		end else begin
			cfg = half && a == ix && v == `PCU_KEY_UNLOCK && AVS_BYTEENABLE[0];
			half = !cfg && a == ix && v == `PCU_KEY_UNLOCK && AVS_BYTEENABLE[0];
		end
		chk(CONFIG_MODE, cfg);
	endtask
	task rd(input [31:0] a);
		bus(1'b0, a, 8'h00);
		if (a == `PCU_IDX_STATUS)
			chk(q, {26'h0, m[0], m[1], m[2], m[3], half[0], cfg[0]});
		else
			chk(q, (cfg && a == dp && mdl[sel] >= 0) ? mdl[sel] : 0);
	endtask
	task chk_out;
		integer c1, c4;
		c1 = mdl[1];
		c4 = mdl[4];
		chk(PORT_BASE_ADDR, c1[1:0] == 1 ? `PCU_BASE_ADDR_A : c1[1:0] == 2 ?
			`PCU_BASE_ADDR_B : c1[1:0] == 3 ? `PCU_BASE_ADDR_C : 0);
		chk(PORT_ENABLE, c1[1:0] != 0);
		if (c1[3]) m = 8;
		else if (!c4[1]) m = c4[0] ? 2 : 4;
		else if (EXTENDED_CONTROL_MODE_FIELD == `PCU_ECM_STD) m = 4;
		else m = (c4[0] && EXTENDED_CONTROL_MODE_FIELD == `PCU_ECM_EPP) ? 2 : 1;
		chk({MODE_COMPAT, MODE_STANDARD_PARALLEL_OPERATION, MODE_EPP, MODE_ECP}, m);
		chk(FIFO_THRESHOLD, mdl[10]);
	endtask
	initial begin
		for (i = 0; i < 256; i = i + 1) mdl[i] = -1;
		mdl[1] = `PCU_RST_PORT_MODE_BASE;
		mdl[4] = `PCU_RST_EXT_SUBMODE;
		mdl[10] = `PCU_RST_FIFO_THRESHOLD;
		cfg = 0;
		half = 0;
		sel = 0;
		repeat (4) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		PWRUP_RST <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		chk_out;
		rd(dp);
		wr(ix, 8'h01);
		wr(ix, 8'h55);
		wr(32'h22000800, 8'h55);
		wr(ix, 8'h55);
		AVS_BYTEENABLE <= 4'h0;
		wr(ix, 8'h55);
		AVS_BYTEENABLE <= 4'h1;
		wr(ix, 8'h55);
		rd(32'h22000800);
		rd(`PCU_IDX_STATUS);
		wr(ix, 8'h55);
		rd(ix);
		for (i = 0; i < 40; i = i + 1) begin
			repeat (8) seed = lfsr(seed);
			s = i[1:0] == 0 ? 8'h01 : i[1:0] == 1 ? 8'h04 : i[1:0] == 2 ? 8'h0a : seed[15:8];
			d = seed[7:0];
			if (s == `PCU_SEL_EXT_SUBMODE) d[7] = 1'b0;
			EXTENDED_CONTROL_MODE_FIELD <= i[3] ? seed[10:8] : {i[2], 2'h0};
			wr(ix, s);
			rd(dp);
			wr(dp, d);
			rd(dp);
			@(posedge CORE_CLK);
			chk_out;
			rd(`PCU_IDX_STATUS);
		end
		SYS_RST <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		@(posedge CORE_CLK);
		cfg = 0;
		half = 0;
		sel = 0;
		chk(CONFIG_MODE, 0);
		chk_out;
		wr(dp, 8'h5a);
		rd(dp);
		wr(ix, 8'h55);
		wr(ix, 8'h55);
		wr(ix, 8'h0a);
		wr(dp, 8'h3c);
		wr(ix, `PCU_KEY_EXIT);
		wr(dp, 8'hc3);
		rd(dp);
		@(posedge CORE_CLK);
		chk_out;
		summarize;
	end
endmodule
bind pcu_config_unlock pcu_cfg_monitor pcu_cfg_monitor_inst (
	.CORE_CLK(CORE_CLK),
	.SYS_RST(SYS_RST),
	.PWRUP_RST(PWRUP_RST),
	.AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.CONFIG_MODE(CONFIG_MODE),
	.PORT_ENABLE(PORT_ENABLE),
	.PORT_BASE_ADDR(PORT_BASE_ADDR),
	.MODE_COMPAT(MODE_COMPAT),
	.MODE_STANDARD_PARALLEL_OPERATION(MODE_STANDARD_PARALLEL_OPERATION),
	.MODE_EPP(MODE_EPP),
	.MODE_ECP(MODE_ECP),
	.FIFO_THRESHOLD(FIFO_THRESHOLD)
);
`default_nettype wire
